// ===== rtl/udh_dma_handshake.v
/*
 * dma request/acknowledge logic for a serial port's transmit and receive
 * fifos, with an axi4-lite slave for control and status.
 * assumes fifo levels arrive synchronous to i_sys_clk, and that the dma
 * controller clock is phase-aligned and an integer multiple of this clock.
 */
// Contract
// (RULE_01) assert active-low burst request when fifo reaches its watermark
// (RULE_02) controller detects new burst request by asserting edge, not level
// (RULE_03) acknowledge asserted drops burst request until acknowledge is released
// (RULE_04) after acknowledge release, reassert burst only if still beyond watermark
// (RULE_05) burst order: request, ack, request off, ack off, optional re-request
// (RULE_06) requests driven on this clock; acks sampled here; clocks phase-aligned
// (RULE_07) burst request holds until acknowledge even if level recedes
// (RULE_08) transmit single asserted with a free entry, cleared when full
// (RULE_09) receive single asserted with a valid entry, cleared when empty
// (RULE_10) controller samples singles only when block not burst multiple
// (RULE_11) single order: single, ack, single off, ack off
// (RULE_12) watermark 4, block 15: three bursts, last three items via single
// (RULE_13) auto flow: rts off at threshold, on at empty, rx burst raised too; code holds rts on while flow_trigger_en is set
// (RULE_14) leftover below threshold after burst raises only receive single
// (RULE_15) controller ignores singles outside its single-transaction region
// (RULE_16) burst length at least receive threshold avoids flow deadlock
// (RULE_17) 32-entry fifo, trigger code 11 gives threshold of 30
// (RULE_18) transmit watermark true when count at or below decoded level
// (RULE_19) receive watermark true when count at or above decoded level
// (RULE_20) all active-low request outputs high from reset onward
`timescale 1ns/1ns
`include "udh_map.vh"

module udh_dma_handshake (
    // clock and reset
    input wire i_sys_clk,
    input wire i_reset_n,
    // fifo levels
    input wire [5:0] i_tx_fifo_count,
    input wire [5:0] i_rx_fifo_count,
    // dma handshake
    input wire i_tx_ack_n,
    input wire i_rx_ack_n,
    output reg o_tx_req_n,
    output reg o_rx_req_n,
    output reg o_tx_single_n,
    output reg o_rx_single_n,
    // modem flow control
    output reg o_rts_n,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // channel states
    localparam ST_IDLE = 2'b00;
    localparam ST_REQ = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [7:0] ctrl;
    reg [1:0] tx_state;
    reg [1:0] rx_state;
    reg [1:0] next_tx_state;
    reg [1:0] next_rx_state;
    reg tx_single_busy;
    reg rx_single_busy;
    reg [5:0] tx_level;
    reg [5:0] rx_level;
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire dma_en = ctrl[`UDH_CTRL_DMA_EN];
    wire auto_flow_enable = ctrl[`UDH_CTRL_AFE];
    wire flow_trigger_en = ctrl[`UDH_CTRL_FLOWTRIG];
    wire [1:0] transmit_empty_trigger_field = ctrl[`UDH_CTRL_TXTRIG_HI:`UDH_CTRL_TXTRIG_LO];
    wire [1:0] receive_trigger_field = ctrl[`UDH_CTRL_RXTRIG_HI:`UDH_CTRL_RXTRIG_LO];

    // trigger decode; code 3 on receive gives two below full
    always @* begin
        case (transmit_empty_trigger_field)
            2'b00: tx_level = `UDH_TXLVL_0;
            2'b01: tx_level = `UDH_TXLVL_1;
            2'b10: tx_level = `UDH_TXLVL_2;
            default: tx_level = `UDH_TXLVL_3;
        endcase
        case (receive_trigger_field)
            2'b00: rx_level = `UDH_RXLVL_0;
            2'b01: rx_level = `UDH_RXLVL_1;
            2'b10: rx_level = `UDH_RXLVL_2;
            default: rx_level = `UDH_RXLVL_3; // RULE_17
        endcase
    end

    // watermark and single conditions
    wire tx_mark = dma_en && (i_tx_fifo_count <= tx_level); // RULE_18
    wire rx_mark = dma_en && (i_rx_fifo_count >= rx_level); // RULE_19
    wire tx_space = dma_en && (i_tx_fifo_count < `UDH_FIFO_DEPTH); // RULE_08
    wire rx_data = dma_en && (i_rx_fifo_count != 6'h00); // RULE_09
    wire tx_ack = !i_tx_ack_n;
    wire rx_ack = !i_rx_ack_n;

    // burst channel next state; acks are sampled on this clock
    always @* begin
        next_tx_state = tx_state;
        case (tx_state)
            ST_IDLE: if (tx_mark && !tx_ack) next_tx_state = ST_REQ; // RULE_01 RULE_04
            ST_REQ: if (tx_ack) next_tx_state = ST_WAIT; // RULE_07 RULE_03
            ST_WAIT: if (!tx_ack) next_tx_state = ST_IDLE; // RULE_05
            default: next_tx_state = ST_IDLE;
        endcase
        next_rx_state = rx_state;
        case (rx_state)
            ST_IDLE: if (rx_mark && !rx_ack) next_rx_state = ST_REQ; // RULE_01 RULE_13
            ST_REQ: if (rx_ack) next_rx_state = ST_WAIT; // RULE_07 RULE_03
            ST_WAIT: if (!rx_ack) next_rx_state = ST_IDLE; // RULE_05
            default: next_rx_state = ST_IDLE;
        endcase
    end

    // registered outputs toward the controller
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            tx_state <= ST_IDLE;
            rx_state <= ST_IDLE;
            tx_single_busy <= 1'b0;
            rx_single_busy <= 1'b0;
            o_tx_req_n <= 1'b1; // RULE_20
            o_rx_req_n <= 1'b1;
            o_tx_single_n <= 1'b1;
            o_rx_single_n <= 1'b1;
        end else begin
            tx_state <= next_tx_state;
            rx_state <= next_rx_state;
            // request driven from flop so the controller sees a clean edge
            o_tx_req_n <= !(next_tx_state == ST_REQ); // RULE_06 RULE_02
            o_rx_req_n <= !(next_rx_state == ST_REQ); // RULE_06 RULE_02
            // single drops while ack is low, returns after ack release
            if (tx_ack)
                tx_single_busy <= 1'b1; // RULE_11
            else
                tx_single_busy <= 1'b0;
            if (rx_ack)
                rx_single_busy <= 1'b1; // RULE_11
            else
                rx_single_busy <= 1'b0;
            o_tx_single_n <= !(tx_space && !tx_ack); // RULE_08 RULE_11
            // below threshold leftovers show only on the single line
            o_rx_single_n <= !(rx_data && !rx_ack); // RULE_09 RULE_14 RULE_12
        end
    end

    // rts: with auto flow on and flow trigger off, off at receive threshold, back on only once drained; else held on
    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_rts_n <= 1'b0;
        end else if (auto_flow_enable && !flow_trigger_en) begin
            if (i_rx_fifo_count >= rx_level)
                o_rts_n <= 1'b1; // RULE_13
            else if (i_rx_fifo_count == 6'h00)
                o_rts_n <= 1'b0; // RULE_13
        end else begin
            o_rts_n <= 1'b0;
        end
    end

    // axi write side: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held || aw_take;
    wire w_have = w_held || w_take;
    wire [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire wr_do = aw_have && w_have && !s_axi_bvalid;

    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UDH_RESP_OKAY;
            ctrl <= `UDH_CTRL_RESET;
        end else begin
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_held <= aw_have && !wr_do;
            w_held <= w_have && !wr_do;
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                // only the control word is writable; others are read-only
                if (wr_addr == `UDH_OFS_CTRL) begin
                    s_axi_bresp <= `UDH_RESP_OKAY;
                    if (wr_strb[0])
                        ctrl <= wr_data[7:0];
                end else begin
                    s_axi_bresp <= `UDH_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read side: one read at a time, answer one cycle after address
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UDH_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `UDH_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
                `UDH_OFS_CTRL: s_axi_rdata[7:0] <= ctrl;
                `UDH_OFS_TXCNT: s_axi_rdata[5:0] <= i_tx_fifo_count;
                `UDH_OFS_RXCNT: s_axi_rdata[5:0] <= i_rx_fifo_count;
                `UDH_OFS_STAT: begin
                    s_axi_rdata[`UDH_STAT_TXREQ] <= !o_tx_req_n;
                    s_axi_rdata[`UDH_STAT_RXREQ] <= !o_rx_req_n;
                    s_axi_rdata[`UDH_STAT_TXSGL] <= !o_tx_single_n;
                    s_axi_rdata[`UDH_STAT_RXSGL] <= !o_rx_single_n;
                    s_axi_rdata[`UDH_STAT_RTS] <= !o_rts_n;
                    s_axi_rdata[`UDH_STAT_TXBUSY] <= tx_single_busy || tx_state == ST_WAIT;
                    s_axi_rdata[`UDH_STAT_RXBUSY] <= rx_single_busy || rx_state == ST_WAIT;
                end
                default: s_axi_rresp <= `UDH_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== rtl/udh_map.vh
/*
 * constants for the serial port dma handshake block: register offsets,
 * field positions, reset values and fifo figures.
 * assumes inclusion by bare name from the design file.
 */
`ifndef UDH_MAP_VH
`define UDH_MAP_VH

// fifo geometry
`define UDH_FIFO_DEPTH 6'h20
`define UDH_CNT_W 6

// register byte offsets
`define UDH_OFS_CTRL 4'h0
`define UDH_OFS_TXCNT 4'h4
`define UDH_OFS_RXCNT 4'h8
`define UDH_OFS_STAT 4'hc

// control register fields
`define UDH_CTRL_DMA_EN 0
`define UDH_CTRL_AFE 1
`define UDH_CTRL_FLOWTRIG 2
`define UDH_CTRL_TXTRIG_LO 4
`define UDH_CTRL_TXTRIG_HI 5
`define UDH_CTRL_RXTRIG_LO 6
`define UDH_CTRL_RXTRIG_HI 7
`define UDH_CTRL_RESET 8'h01

// status register fields
`define UDH_STAT_TXREQ 0
`define UDH_STAT_RXREQ 1
`define UDH_STAT_TXSGL 2
`define UDH_STAT_RXSGL 3
`define UDH_STAT_RTS 4
`define UDH_STAT_TXBUSY 5
`define UDH_STAT_RXBUSY 6

// trigger decodes (entries)
`define UDH_TXLVL_0 6'h00
`define UDH_TXLVL_1 6'h02
`define UDH_TXLVL_2 6'h08
`define UDH_TXLVL_3 6'h10
`define UDH_RXLVL_0 6'h01
`define UDH_RXLVL_1 6'h08
`define UDH_RXLVL_2 6'h10
`define UDH_RXLVL_3 6'h1e

// axi responses
`define UDH_RESP_OKAY 2'h0
`define UDH_RESP_SLVERR 2'h2

`endif

// ===== sim/udh_props.sv
/* checker for the dma handshake outputs of the serial port block.
   assumes binding to udh_dma_handshake, reset synchronous and active low. */
`timescale 1ns/1ns
module udh_props (
    // clock, reset, fifo levels
    input wire i_sys_clk,
    input wire i_reset_n,
    input wire [5:0] i_tx_fifo_count,
    input wire [5:0] i_rx_fifo_count,
    // handshake lines
    input wire i_tx_ack_n,
    input wire i_rx_ack_n,
    input wire o_tx_req_n,
    input wire o_rx_req_n,
    input wire o_tx_single_n,
    input wire o_rx_single_n,
    input wire o_rts_n
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // a grant is the acknowledge seen low
    sequence s_tx_grant;
        !i_tx_ack_n;
    endsequence
    sequence s_rx_grant;
        !i_rx_ack_n;
    endsequence
    a_tx_grant_drop: assert property (
        s_tx_grant |=> o_tx_req_n && o_tx_single_n) else $error("tx request kept under grant");
    a_rx_grant_drop: assert property (
        s_rx_grant |=> o_rx_req_n && o_rx_single_n) else $error("rx request kept under grant");
    a_tx_req_hold: assert property (
        !o_tx_req_n && i_tx_ack_n |=> !o_tx_req_n) else $error("tx request dropped early");
    a_rx_req_hold: assert property (
        !o_rx_req_n && i_rx_ack_n |=> !o_rx_req_n) else $error("rx request dropped early");
    a_tx_rise_cause: assert property (
        $rose(o_tx_req_n) |-> !$past(i_tx_ack_n)) else $error("tx request fell without grant");
    a_rx_fall_cause: assert property (
        $fell(o_rx_req_n) |-> $past(i_rx_ack_n)) else $error("rx request raised under grant");
    a_tx_full_single: assert property (
        i_tx_fifo_count == 6'h20 |=> o_tx_single_n) else $error("tx single while full");
    a_rx_empty_single: assert property (
        i_rx_fifo_count == 6'h00 |=> o_rx_single_n) else $error("rx single while empty");
    a_rx_data_single: assert property (
        i_rx_fifo_count != 6'h00 && i_rx_ack_n |=> !o_rx_single_n) else $error("rx single missing");
    a_rts_empty: assert property (
        i_rx_fifo_count == 6'h00 |=> !o_rts_n) else $error("rts not asserted when empty");
    a_reset_idle: assert property (disable iff (1'b0)
        !i_reset_n |=> o_tx_req_n && o_rx_req_n && o_tx_single_n && o_rx_single_n)
        else $error("request active after reset");
endmodule
bind udh_dma_handshake udh_props u_props (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_tx_fifo_count(i_tx_fifo_count), .i_rx_fifo_count(i_rx_fifo_count),
    .i_tx_ack_n(i_tx_ack_n), .i_rx_ack_n(i_rx_ack_n), .o_tx_req_n(o_tx_req_n),
    .o_rx_req_n(o_rx_req_n), .o_tx_single_n(o_tx_single_n), .o_rx_single_n(o_rx_single_n),
    .o_rts_n(o_rts_n));

// ===== sim/udh_dmac_model.sv
/* behavioural dma controller channel facing the handshake block.
   assumes its clock is the peripheral clock itself, the 1:1 case. */
`timescale 1ns/1ns
module udh_dmac_model (
    // clock and bench controls
    input wire i_clk,
    input wire i_single_ok,
    input wire [3:0] i_wait,
    // handshake
    input wire i_req_n,
    input wire i_single_n,
    output reg o_ack_n,
    output reg [7:0] o_bursts
);
    reg last_req_n = 1'b1;
    reg busy = 1'b0;
    reg [3:0] cnt = 4'h0;
    // level alone never starts a burst; singles only inside the single region
    wire want = (last_req_n && !i_req_n) || (i_single_ok && !i_single_n);
    initial o_ack_n = 1'b1;
    initial o_bursts = 8'h00;
    // service delay, grant, then release once the request has dropped
    always @(posedge i_clk) begin
        last_req_n <= i_req_n;
        if (!busy && want) begin
            busy <= 1'b1;
            cnt <= i_wait;
        end else if (busy && o_ack_n && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (busy && o_ack_n) begin
            o_ack_n <= 1'b0;
            o_bursts <= o_bursts + {7'h00, !i_req_n};
        end else if (busy && i_req_n && i_single_n) begin
            o_ack_n <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule

// ===== sim/udh_dma_handshake_tb.sv
/* self-checking bench for the serial port dma handshake block.
   assumes the controller model and checker are compiled alongside. */
`timescale 1ns/1ns
module udh_dma_handshake_tb;
    reg clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, tok = 0, rok = 0, rxo = 1;
    reg [5:0] txc = 6'h20, rxc = 6'h00;
    reg [3:0] aw = 0, ar = 0, txw = 4'h4, rxw = 4'h2;
    reg [31:0] wd = 0, q, r;
    reg [1:0] rsp;
    wire tak, rak, txq, rxq, txs, rxs, rts, awr, wr, bv, arr, rv;
    wire [1:0] bresp, rresp;
    wire [31:0] rd;
    wire [7:0] txb, rxb;
    integer errors = 0, checks_done = 0, seed = 32'h801791da, i, fed = 0;
    udh_dma_handshake uut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_tx_fifo_count(txc),
        .i_rx_fifo_count(rxc), .i_tx_ack_n(tak), .i_rx_ack_n(rak), .o_tx_req_n(txq),
        .o_rx_req_n(rxq), .o_tx_single_n(txs), .o_rx_single_n(rxs), .o_rts_n(rts),
        .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));
    udh_dmac_model txm (.i_clk(clk), .i_single_ok(tok), .i_wait(txw), .i_req_n(txq),
        .i_single_n(txs), .o_ack_n(tak), .o_bursts(txb));
    udh_dmac_model rxm (.i_clk(clk), .i_single_ok(rok), .i_wait(rxw), .i_req_n(rxq),
        .i_single_n(rxs), .o_ack_n(rak), .o_bursts(rxb));
    always #5 clk = !clk;
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input [8*6:1] nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("MISMATCH %0s expected %0h seen %0h", nm, e, g);
            end
        end
    endtask
    // one transfer; each channel released when taken, answer awaited
    task axi(input w, input [3:0] a, input [31:0] d);
        begin
            aw <= a; ar <= a; wd <= d; awv <= w; wv <= w; br <= w; arv <= !w; rr <= !w;
            do begin
                @(posedge clk);
                if (awr) awv <= 0;
                if (wr) wv <= 0;
                if (arr) arv <= 0;
            end while (!(w ? bv : rv));
            q = rd;
            rsp = w ? bresp : rresp;
            br <= 0;
            rr <= 0;
            @(posedge clk);
        end
    endtask
    // receive side: items arrive, bursts take eight, singles take one
    task feed(input integer n);
        for (i = 0; i < n; i = i + 1) begin
            @(posedge clk);
            // burst of eight matches the receive level of eight, so no deadlock
            if (!rak && rxo) rxc <= rxc - (rxq ? 6'h01 : 6'h08);
            else if (rxq && rak && fed < 27) begin
                rxc <= rxc + 6'h01;
                fed = fed + 1;
            end
            rxo = rak;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        #100000;
        errors = errors + 1;
        print_verdict;
    end
    initial begin
        wt(8);
        chk("idle", 5'h1e, {txq, rxq, txs, rxs, rts});
        rst_n <= 1;
        axi(0, 4'h0, 0);
        chk("ctrl", 32'h0000_0001, q);
        axi(1, 4'hc, 32'h0000_ffff);
        chk("bresp", 2'h2, rsp);
        axi(0, 4'h2, 0);
        chk("rresp", 2'h2, rsp);
        axi(1, 4'h0, 32'h0000_0061);
        $display("register test done");
        r = $random(seed);
        txw <= {2'b00, r[5:4]} + 4'h4;
        txc <= 6'h09;
        wt(3);
        chk("txq", 1, txq);
        chk("txs", 0, txs);
        txc <= 6'h08;
        wt(3);
        chk("txq", 0, txq);
        txc <= 6'h09 + {2'b00, r[3:0]};
        wt(3);
        chk("txq", 0, txq);
        wt(16);
        chk("txq", 1, txq);
        chk("txb", 1, txb);
        tok <= 1;
        wt(40);
        tok <= 0;
        txc <= 6'h20;
        wt(20);
        chk("txs", 1, txs);
        $display("transmit test done");
        rxw <= {2'b00, r[7:6]};
        feed(200);
        chk("rxb", 3, rxb);
        chk("rxq", 1, rxq);
        chk("rxs", 0, rxs);
        rok <= 1;
        feed(150);
        chk("rxc", 0, rxc);
        chk("rxs", 1, rxs);
        rok <= 0;
        $display("receive test done");
        rxw <= 4'hf;
        axi(1, 4'h0, 32'h0000_00e3);
        rxc <= 6'h1d;
        wt(3);
        chk("rts", 0, rts);
        rxc <= 6'h1e;
        wt(3);
        chk("rts", 1, rts);
        chk("rxq", 0, rxq);
        rxc <= 6'h0e;
        wt(25);
        chk("rts", 1, rts);
        chk("rxq", 1, rxq);
        rxc <= 6'h00;
        wt(3);
        chk("rts", 0, rts);
        $display("flow control test done");
        print_verdict;
    end
endmodule
